// [logic/fp_bank_pkg.sv]
// Types shared by the vector bank addressing logic.
package fp_bank_pkg;

  typedef enum logic [1:0] {
    OP_ARITH3,
    OP_ARITH2,
    OP_SCALAR_ONLY,
    OP_MULTI
  } op_kind_e;

  typedef enum {SEQ_IDLE, SEQ_RUN} seq_state_e;

  typedef enum {ST_IDLE, ST_SECOND} st_state_e;

  typedef logic [4:0] reg_idx_t;

endpackage

// [logic/fp_bank_regs.svh]
// Register offsets, field positions, reset values and address constants.
`ifndef FP_BANK_REGS_SVH
`define FP_BANK_REGS_SVH

`define FPB_CTRL_OFF 8'h00
`define FPB_STAT_OFF 8'h04
`define FPB_OPCNT_OFF 8'h08

`define FPB_LEN_LSB 0
`define FPB_LEN_MSB 2
`define FPB_STRIDE_LSB 4
`define FPB_STRIDE_MSB 5
`define FPB_CTRL_MASK 32'h0000_0037
`define FPB_CTRL_RST 32'h0000_0000

`define FPB_STAT_BUSY_BIT 0
`define FPB_STAT_BIG_BIT 1
`define FPB_STAT_REM_LSB 4
`define FPB_STAT_REM_MSB 8

`define FPB_WORD_MASK 32'hffff_fffc
`define FPB_HIGH_WORD_OFF 32'h0000_0004
`define FPB_BE_BYTE_XOR 32'h0000_0003
`define FPB_STRIDE_ONE 2'h0

`endif

// [logic/fp_vector_bank_addressing.sv]
// Register bank addressing, vector sequencing and store lane placement.
//
// Our own choices: the APB register port and the address map.
`timescale 1ns/100ps
`include "fp_bank_regs.svh"

// Overview of operation
// (RULE_01) Words stored least byte at lowest address.
// (RULE_02) Single store: LSB low address, MSB top.
// (RULE_03) Big-endian byte address flips low two bits.
// (RULE_04) Double words swap places when big-endian.
// (RULE_05) Software aligns singles four, doubles eight bytes.
// (RULE_06) Endianness comes from system control input.
// (RULE_07) Four banks: eight singles or four doubles.
// (RULE_08) Vector operands wrap within their own bank.
// (RULE_09) Multiple load/store steps linearly, no wrap.
// (RULE_10) Iterations equal length field plus one.
// (RULE_11) Stride b00 advances indices by one.
// (RULE_12) Compares and conversions always run scalar.
// (RULE_13) Bank-0 destination forces one scalar operation.
// (RULE_14) Bank-0 second source stays fixed each iteration.
// (RULE_15) Both outside bank 0: all indices step.
// (RULE_16) Two-operand ops use the same classification.
// (RULE_17) Doubles: 0-3 bank 0, 4-15 vector banks.
// (RULE_18) First source always steps in vector operations.
// (RULE_19) Device does endian address transformations itself.
// (RULE_20) Length and stride come from status/control register.
// (RULE_21) Double register is even/odd single pair.
// (RULE_22) Other stride encodings step by two, wrapping.
module fp_vector_bank_addressing (
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic sysctl_endian_big,
  input wire logic op_valid,
  input wire fp_bank_pkg::op_kind_e op_kind,
  input wire logic op_dp,
  input wire fp_bank_pkg::reg_idx_t dest_reg_index,
  input wire fp_bank_pkg::reg_idx_t first_src_reg_index,
  input wire fp_bank_pkg::reg_idx_t second_src_reg_index,
  input wire logic [4:0] op_count,
  output logic op_ready,
  output logic iter_valid,
  output logic iter_last,
  output logic iter_dp,
  output fp_bank_pkg::reg_idx_t iter_dest,
  output fp_bank_pkg::reg_idx_t iter_first,
  output fp_bank_pkg::reg_idx_t iter_second,
  input wire logic st_valid,
  input wire logic st_dp,
  input wire logic [31:0] st_addr,
  input wire logic [63:0] st_data,
  output logic st_ready,
  output logic mem_valid,
  output logic [31:0] mem_addr,
  output logic [31:0] mem_wdata,
  input wire logic xlat_req,
  input wire logic [31:0] xlat_addr_in,
  output logic xlat_valid,
  output logic [31:0] xlat_addr
);

  // Register bus state.
  logic [31:0] prdata_r, prdata_nxt, opcnt_r, opcnt_nxt;
  logic pready_r, pready_nxt, pslverr_r, pslverr_nxt;
  logic [31:0] fp_status_control_reg_r, fp_status_control_reg_nxt;
  logic [2:0] vector_length_field;
  logic [1:0] stride_field;

  // Sequencer state.
  fp_bank_pkg::seq_state_e seq_state_r, seq_state_nxt;
  logic [4:0] remain_r, remain_nxt;
  fp_bank_pkg::reg_idx_t dest_r, dest_nxt, first_r, first_nxt;
  fp_bank_pkg::reg_idx_t second_r, second_nxt, iter_dest_r, iter_dest_nxt;
  fp_bank_pkg::reg_idx_t iter_first_r, iter_first_nxt;
  fp_bank_pkg::reg_idx_t iter_second_r, iter_second_nxt;
  logic dp_r, dp_nxt, linear_r, linear_nxt, iter_dp_r, iter_dp_nxt;
  logic step_second_r, step_second_nxt, op_ready_r, op_ready_nxt;
  logic [2:0] step_r, step_nxt;
  logic iter_valid_r, iter_valid_nxt, iter_last_r, iter_last_nxt;

  // Store lane state.
  fp_bank_pkg::st_state_e st_state_r, st_state_nxt;
  logic [31:0] pend_word_r, pend_word_nxt, pend_addr_r, pend_addr_nxt;
  logic st_ready_r, st_ready_nxt, mem_valid_r, mem_valid_nxt;
  logic [31:0] mem_addr_r, mem_addr_nxt, mem_wdata_r, mem_wdata_nxt;

  // Byte address translation state.
  logic xlat_valid_r, xlat_valid_nxt;
  logic [31:0] xlat_addr_r, xlat_addr_nxt;

  logic apb_done, op_take, st_take;

  // Bank test: singles bank is idx[4:3], doubles bank is idx[3:2].
  function automatic logic in_bank0(input logic [4:0] idx, input logic dp);
    in_bank0 = dp ? (idx[3:2] == 2'h0) : (idx[4:3] == 2'h0);  // [RULE_17]
  endfunction

  // Circular step inside the operand's bank.
  function automatic logic [4:0] bank_step(input logic [4:0] idx,
                                           input logic dp,
                                           input logic [2:0] amt);
    bank_step = dp ? {1'b0, idx[3:2], 2'(idx[1:0] + amt[1:0])} :  // [RULE_08]
                {idx[4:3], 3'(idx[2:0] + amt)};  // [RULE_08] [RULE_07]
  endfunction

  // Linear step over the whole file, used for multiple transfers.
  function automatic logic [4:0] lin_step(input logic [4:0] idx,
                                          input logic dp);
    lin_step = dp ? {1'b0, 4'(idx[3:0] + 4'h1)} :  // [RULE_09]
               5'(idx + 5'h01);  // [RULE_09]
  endfunction

  // Singles index of a double is its even half; the odd one is upper.
  function automatic logic [4:0] to_single(input logic [4:0] idx,
                                           input logic dp);
    to_single = dp ? {idx[3:0], 1'b0} : idx;  // [RULE_21]
  endfunction

  assign vector_length_field =
    fp_status_control_reg_r[`FPB_LEN_MSB:`FPB_LEN_LSB];  // [RULE_20]
  assign stride_field =
    fp_status_control_reg_r[`FPB_STRIDE_MSB:`FPB_STRIDE_LSB];  // [RULE_20]

  // The slave inserts one wait cycle so every answer comes from a flop.
  assign apb_done = psel && penable && pready_r;
  assign op_take = op_valid && op_ready_r;
  assign st_take = st_valid && st_ready_r;

  always_comb begin
    prdata_nxt = 32'h0000_0000;
    pready_nxt = 1'b0;
    pslverr_nxt = 1'b0;
    fp_status_control_reg_nxt = fp_status_control_reg_r;
    opcnt_nxt = op_take ? 32'(opcnt_r + 32'h1) : opcnt_r;
    if (apb_done && pwrite && paddr == `FPB_CTRL_OFF) begin
      fp_status_control_reg_nxt = pwdata & `FPB_CTRL_MASK;
    end
    if (psel && penable && !pready_r) begin
      pready_nxt = 1'b1;
      case (paddr)
        `FPB_CTRL_OFF: prdata_nxt = fp_status_control_reg_r;
        `FPB_STAT_OFF: begin
          prdata_nxt[`FPB_STAT_BUSY_BIT] = !op_ready_r;
          prdata_nxt[`FPB_STAT_BIG_BIT] = sysctl_endian_big;
          prdata_nxt[`FPB_STAT_REM_MSB:`FPB_STAT_REM_LSB] = remain_r;
        end
        `FPB_OPCNT_OFF: prdata_nxt = opcnt_r;
        default: pslverr_nxt = 1'b1;
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      prdata_r <= 32'h0000_0000;
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      fp_status_control_reg_r <= `FPB_CTRL_RST;
      opcnt_r <= 32'h0000_0000;
    end else begin
      prdata_r <= prdata_nxt;
      pready_r <= pready_nxt;
      pslverr_r <= pslverr_nxt;
      fp_status_control_reg_r <= fp_status_control_reg_nxt;
      opcnt_r <= opcnt_nxt;
    end
  end

  // The first iteration leaves on the accept edge; later ones follow
  // back to back, one per cycle, with no stall from the consumer.
  always_comb begin
    logic vec;
    vec = 1'b0;
    seq_state_nxt = seq_state_r;
    remain_nxt = remain_r;
    dest_nxt = dest_r;
    first_nxt = first_r;
    second_nxt = second_r;
    dp_nxt = dp_r;
    linear_nxt = linear_r;
    step_second_nxt = step_second_r;
    step_nxt = step_r;
    op_ready_nxt = op_ready_r;
    iter_valid_nxt = 1'b0;
    iter_last_nxt = 1'b0;
    iter_dp_nxt = iter_dp_r;
    iter_dest_nxt = iter_dest_r;
    iter_first_nxt = iter_first_r;
    iter_second_nxt = iter_second_r;
    case (seq_state_r)
      fp_bank_pkg::SEQ_IDLE: begin
        if (op_take) begin
          vec = (vector_length_field != 3'h0) &&  // [RULE_16]
                (op_kind != fp_bank_pkg::OP_SCALAR_ONLY) &&  // [RULE_12]
                !in_bank0(dest_reg_index, op_dp);  // [RULE_13] [RULE_17]
          dp_nxt = op_dp;
          linear_nxt = (op_kind == fp_bank_pkg::OP_MULTI);
          // Bank-0 second source is a scalar held fixed.
          step_second_nxt = vec &&
            !in_bank0(second_src_reg_index, op_dp);  // [RULE_14] [RULE_15]
          step_nxt = (stride_field == `FPB_STRIDE_ONE) ?
                     3'h1 : 3'h2;  // [RULE_11] [RULE_22]
          dest_nxt = dest_reg_index;
          first_nxt = first_src_reg_index;
          second_nxt = second_src_reg_index;
          remain_nxt = vec ? {2'h0, vector_length_field} : 5'h00;  // [RULE_10]
          if (op_kind == fp_bank_pkg::OP_MULTI) begin
            remain_nxt = op_count;  // [RULE_09]
          end
          iter_valid_nxt = 1'b1;
          iter_last_nxt = (remain_nxt == 5'h00);
          iter_dp_nxt = op_dp;
          iter_dest_nxt = to_single(dest_reg_index, op_dp);  // [RULE_21]
          iter_first_nxt = to_single(first_src_reg_index, op_dp);
          iter_second_nxt = to_single(second_src_reg_index, op_dp);
          if (remain_nxt != 5'h00) begin
            seq_state_nxt = fp_bank_pkg::SEQ_RUN;
            op_ready_nxt = 1'b0;
          end
        end
      end
      fp_bank_pkg::SEQ_RUN: begin
        if (linear_r) begin
          dest_nxt = lin_step(dest_r, dp_r);  // [RULE_09]
        end else begin
          dest_nxt = bank_step(dest_r, dp_r, step_r);  // [RULE_15]
          first_nxt = bank_step(first_r, dp_r, step_r);  // [RULE_18]
          if (step_second_r) begin
            second_nxt = bank_step(second_r, dp_r, step_r);  // [RULE_15]
          end
        end
        remain_nxt = 5'(remain_r - 5'h01);
        iter_valid_nxt = 1'b1;
        iter_last_nxt = (remain_nxt == 5'h00);
        iter_dest_nxt = to_single(dest_nxt, dp_r);
        iter_first_nxt = to_single(first_nxt, dp_r);
        iter_second_nxt = to_single(second_nxt, dp_r);
        if (remain_nxt == 5'h00) begin
          seq_state_nxt = fp_bank_pkg::SEQ_IDLE;
          op_ready_nxt = 1'b1;
        end
      end
      default: begin
        seq_state_nxt = fp_bank_pkg::SEQ_IDLE;
        op_ready_nxt = 1'b1;
      end
    endcase
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      seq_state_r <= fp_bank_pkg::SEQ_IDLE;
      remain_r <= 5'h00;
      dest_r <= 5'h00;
      first_r <= 5'h00;
      second_r <= 5'h00;
      dp_r <= 1'b0;
      linear_r <= 1'b0;
      step_second_r <= 1'b0;
      step_r <= 3'h1;
      op_ready_r <= 1'b1;
      iter_valid_r <= 1'b0;
      iter_last_r <= 1'b0;
      iter_dp_r <= 1'b0;
      iter_dest_r <= 5'h00;
      iter_first_r <= 5'h00;
      iter_second_r <= 5'h00;
    end else begin
      seq_state_r <= seq_state_nxt;
      remain_r <= remain_nxt;
      dest_r <= dest_nxt;
      first_r <= first_nxt;
      second_r <= second_nxt;
      dp_r <= dp_nxt;
      linear_r <= linear_nxt;
      step_second_r <= step_second_nxt;
      step_r <= step_nxt;
      op_ready_r <= op_ready_nxt;
      iter_valid_r <= iter_valid_nxt;
      iter_last_r <= iter_last_nxt;
      iter_dp_r <= iter_dp_nxt;
      iter_dest_r <= iter_dest_nxt;
      iter_first_r <= iter_first_nxt;
      iter_second_r <= iter_second_nxt;
    end
  end

  // Each 32-bit word goes out unchanged in its lanes, so the in-word
  // image never depends on endianness; only word order does.
  always_comb begin
    logic [31:0] base;
    base = st_addr & `FPB_WORD_MASK;  // [RULE_02]
    st_state_nxt = st_state_r;
    pend_word_nxt = pend_word_r;
    pend_addr_nxt = pend_addr_r;
    st_ready_nxt = st_ready_r;
    mem_valid_nxt = 1'b0;
    mem_addr_nxt = mem_addr_r;
    mem_wdata_nxt = mem_wdata_r;
    case (st_state_r)
      fp_bank_pkg::ST_IDLE: begin
        if (st_take) begin
          mem_valid_nxt = 1'b1;
          mem_addr_nxt = base;
          if (!st_dp) begin
            mem_wdata_nxt = st_data[31:0];  // [RULE_01] [RULE_19]
          end else begin
            // Big-endian puts the high word first.
            mem_wdata_nxt = sysctl_endian_big ?
                            st_data[63:32] : st_data[31:0];  // [RULE_04]
            pend_word_nxt = sysctl_endian_big ?
                            st_data[31:0] : st_data[63:32];  // [RULE_06]
            pend_addr_nxt = 32'(base + `FPB_HIGH_WORD_OFF);  // [RULE_04]
            st_state_nxt = fp_bank_pkg::ST_SECOND;
            st_ready_nxt = 1'b0;
          end
        end
      end
      fp_bank_pkg::ST_SECOND: begin
        mem_valid_nxt = 1'b1;
        mem_addr_nxt = pend_addr_r;
        mem_wdata_nxt = pend_word_r;  // [RULE_01]
        st_state_nxt = fp_bank_pkg::ST_IDLE;
        st_ready_nxt = 1'b1;
      end
      default: begin
        st_state_nxt = fp_bank_pkg::ST_IDLE;
        st_ready_nxt = 1'b1;
      end
    endcase
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      st_state_r <= fp_bank_pkg::ST_IDLE;
      pend_word_r <= 32'h0000_0000;
      pend_addr_r <= 32'h0000_0000;
      st_ready_r <= 1'b1;
      mem_valid_r <= 1'b0;
      mem_addr_r <= 32'h0000_0000;
      mem_wdata_r <= 32'h0000_0000;
    end else begin
      st_state_r <= st_state_nxt;
      pend_word_r <= pend_word_nxt;
      pend_addr_r <= pend_addr_nxt;
      st_ready_r <= st_ready_nxt;
      mem_valid_r <= mem_valid_nxt;
      mem_addr_r <= mem_addr_nxt;
      mem_wdata_r <= mem_wdata_nxt;
    end
  end

  // Programmer byte address to memory byte address; flipping the two
  // low bits also covers doubles because their words already swapped.
  always_comb begin
    xlat_valid_nxt = xlat_req;
    xlat_addr_nxt = !xlat_req ? xlat_addr_r :
                    sysctl_endian_big ?
                    (xlat_addr_in ^ `FPB_BE_BYTE_XOR) :  // [RULE_03]
                    xlat_addr_in;  // [RULE_19]
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      xlat_valid_r <= 1'b0;
      xlat_addr_r <= 32'h0000_0000;
    end else begin
      xlat_valid_r <= xlat_valid_nxt;
      xlat_addr_r <= xlat_addr_nxt;
    end
  end

  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;
  assign op_ready = op_ready_r;
  assign iter_valid = iter_valid_r;
  assign iter_last = iter_last_r;
  assign iter_dp = iter_dp_r;
  assign iter_dest = iter_dest_r;
  assign iter_first = iter_first_r;
  assign iter_second = iter_second_r;
  assign st_ready = st_ready_r;
  assign mem_valid = mem_valid_r;
  assign mem_addr = mem_addr_r;
  assign mem_wdata = mem_wdata_r;
  assign xlat_valid = xlat_valid_r;
  assign xlat_addr = xlat_addr_r;

endmodule

// [testbench/fp_store_mem_model.sv]
// Memory model on the store side that keeps a byte image of written words.
`timescale 1ns/100ps
module fp_store_mem_model (
  input wire logic ref_clk,
  input wire logic mem_valid,
  input wire logic [31:0] mem_addr,
  input wire logic [31:0] mem_wdata
);
  logic [7:0] bytes [0:15];

  // Only the low address bits are kept, so tests stay inside one window.
  always @(posedge ref_clk) begin
    if (mem_valid === 1'b1) begin
      for (int b = 0; b < 4; b++) begin
        bytes[{mem_addr[3:2], 2'(b)}] <= mem_wdata[8*b +: 8];
      end
    end
  end
endmodule

// [testbench/fp_vector_bank_addressing_properties.sv]
// Port-level assertions for the vector bank addressing block.
`timescale 1ns/100ps
module fp_vector_bank_addressing_props (
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic psel,
  input wire logic penable,
  input wire logic [7:0] paddr,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic sysctl_endian_big,
  input wire logic op_valid,
  input wire logic op_ready,
  input wire fp_bank_pkg::op_kind_e op_kind,
  input wire logic op_dp,
  input wire fp_bank_pkg::reg_idx_t dest_reg_index,
  input wire logic iter_valid,
  input wire logic iter_last,
  input wire logic iter_dp,
  input wire fp_bank_pkg::reg_idx_t iter_dest,
  input wire fp_bank_pkg::reg_idx_t iter_first,
  input wire logic st_valid,
  input wire logic st_ready,
  input wire logic st_dp,
  input wire logic [31:0] st_addr,
  input wire logic [63:0] st_data,
  input wire logic mem_valid,
  input wire logic [31:0] mem_addr,
  input wire logic [31:0] mem_wdata,
  input wire logic xlat_req,
  input wire logic [31:0] xlat_addr_in,
  input wire logic xlat_valid,
  input wire logic [31:0] xlat_addr
);
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rst_b);

  AST_XLAT: assert property (
    xlat_req |=> xlat_valid && xlat_addr == ($past(sysctl_endian_big) ?
    $past(xlat_addr_in) ^ 32'h0000_0003 : $past(xlat_addr_in)))
    else $error("translated address wrong");
  AST_ST_FIRST: assert property (
    st_valid && st_ready |=> mem_valid &&
    mem_addr == ($past(st_addr) & 32'hffff_fffc) &&
    mem_wdata == ($past(st_dp) && $past(sysctl_endian_big) ?
    $past(st_data[63:32]) : $past(st_data[31:0])))
    else $error("first store word wrong");
  AST_ST_SECOND: assert property (
    st_valid && st_ready && st_dp |=> !st_ready ##1 mem_valid &&
    mem_addr == ($past(st_addr, 2) & 32'hffff_fffc) + 32'h0000_0004 &&
    mem_wdata == ($past(sysctl_endian_big, 2) ?
    $past(st_data[31:0], 2) : $past(st_data[63:32], 2)))
    else $error("second store word wrong");
  AST_FIRST_ITER: assert property (
    op_valid && op_ready |=> iter_valid && iter_dp == $past(op_dp) &&
    iter_dest == ($past(op_dp) ? {$past(dest_reg_index[3:0]), 1'b0} :
    $past(dest_reg_index)))
    else $error("first iteration wrong");
  AST_SCALAR: assert property (
    op_valid && op_ready && op_kind != fp_bank_pkg::OP_MULTI &&
    (op_kind == fp_bank_pkg::OP_SCALAR_ONLY ||
    (op_dp ? dest_reg_index[3:2] : dest_reg_index[4:3]) == 2'h0)
    |=> iter_last)
    else $error("scalar operation not single");
  AST_LAST_READY: assert property (
    iter_valid |-> op_ready == iter_last)
    else $error("ready and last disagree");
  AST_DP_EVEN: assert property (
    iter_valid && iter_dp |-> !iter_dest[0] && !iter_first[0])
    else $error("double index odd");
  AST_APB_READY: assert property (
    psel && penable && !pready |=> pready)
    else $error("apb answer late");
  AST_APB_ERR: assert property (
    psel && penable && pready && (paddr > 8'h08 || paddr[1:0] != 2'h0)
    |-> pslverr)
    else $error("unmapped access not refused");

  COV_VEC: cover property (iter_valid && !iter_last ##1 iter_valid);
  COV_DP_BIG: cover property (st_valid && st_ready && st_dp &&
    sysctl_endian_big);
  COV_ERR: cover property (pready && pslverr);
endmodule

bind fp_vector_bank_addressing fp_vector_bank_addressing_props u_props (.*);

// [testbench/fp_vector_bank_addressing_tb.sv]
// Self-checking testbench for the vector bank addressing block.
`timescale 1ns/100ps
module fp_vector_bank_addressing_tb;
  logic ref_clk = 1'b0, rst_b = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata;
  logic pready, pslverr, sysctl_endian_big = 1'b0;
  logic op_valid = 1'b0, op_dp = 1'b0, op_ready;
  fp_bank_pkg::op_kind_e op_kind = fp_bank_pkg::OP_ARITH3;
  fp_bank_pkg::reg_idx_t dest_reg_index = 5'h00;
  fp_bank_pkg::reg_idx_t first_src_reg_index = 5'h00;
  fp_bank_pkg::reg_idx_t second_src_reg_index = 5'h00;
  fp_bank_pkg::reg_idx_t iter_dest, iter_first, iter_second;
  logic [4:0] op_count = 5'h00;
  logic iter_valid, iter_last, iter_dp, st_ready, mem_valid, xlat_valid;
  logic st_valid = 1'b0, st_dp = 1'b0, xlat_req = 1'b0;
  logic [31:0] st_addr = 32'h0, xlat_addr_in = 32'h0;
  logic [31:0] mem_addr, mem_wdata, xlat_addr;
  logic [63:0] st_data = 64'h0;
  int mismatches = 0;
  int checked = 0;

  fp_vector_bank_addressing u_dut (.*);
  fp_store_mem_model u_mem (.*);

  always #50 ref_clk = ~ref_clk;

  task automatic stop_test;
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [63:0] exp,
                     input logic [63:0] got);
    checked++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic timeout(input string what);
    mismatches++;
    $display("mismatch %s expected answer seen timeout", what);
    stop_test();
  endtask

  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] wd, output logic [31:0] rd,
                     output logic err);
    int n;
    n = 0;
    @(posedge ref_clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge ref_clk);
    penable <= 1'b1;
    do begin
      @(posedge ref_clk);
      if (++n > 20) timeout("pready");
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr_ctrl(input logic [2:0] len, input logic [1:0] str);
    logic [31:0] rd;
    logic err;
    apb(1'b1, 8'h00, {26'h0, str, 1'b0, len}, rd, err);
  endtask

  // Expected register of one operand after k steps, in single units.
  function automatic logic [4:0] stepx(input logic [4:0] i, input int k,
                                       input logic dp, input logic wrap);
    logic [4:0] r;
    if (dp)
      r = wrap ? {1'b0, i[3:2], 2'(i[1:0] + k)} : {1'b0, 4'(i[3:0] + k)};
    else
      r = wrap ? {i[4:3], 3'(i[2:0] + k)} : 5'(i + k);
    return dp ? {r[3:0], 1'b0} : r;
  endfunction

  task automatic run_op(input fp_bank_pkg::op_kind_e k, input logic dp,
                        input logic [4:0] d, n, m, input int cnt,
                        input int sd, sn, sm, input logic wrap);
    int w;
    w = 0;
    @(posedge ref_clk);
    op_valid <= 1'b1;
    op_kind <= k;
    op_dp <= dp;
    dest_reg_index <= d;
    first_src_reg_index <= n;
    second_src_reg_index <= m;
    op_count <= 5'(cnt - 1);
    do begin
      @(posedge ref_clk);
      if (++w > 50) timeout("op accept");
    end while (op_ready !== 1'b1);
    op_valid <= 1'b0;
    for (int i = 0; i < cnt; i++) begin
      @(negedge ref_clk);
      chk("iter_valid", 1'b1, iter_valid);
      chk("iter_last", i == cnt - 1, iter_last);
      chk("iter_dp", dp, iter_dp);
      chk("iter_dest", stepx(d, i * sd, dp, wrap), iter_dest);
      if (k != fp_bank_pkg::OP_MULTI) begin
        chk("iter_first", stepx(n, i * sn, dp, wrap), iter_first);
        chk("iter_second", stepx(m, i * sm, dp, wrap), iter_second);
      end
      @(posedge ref_clk);
    end
  endtask

  task automatic store(input logic dp, big, input logic [31:0] a,
                       input logic [63:0] v);
    logic [63:0] got;
    @(posedge ref_clk);
    sysctl_endian_big <= big;
    st_valid <= 1'b1;
    st_dp <= dp;
    st_addr <= a;
    st_data <= v;
    @(posedge ref_clk);
    st_valid <= 1'b0;
    repeat (dp ? 2 : 1) @(posedge ref_clk);
    @(negedge ref_clk);
    for (int b = 0; b < 8; b++) got[8*b +: 8] = u_mem.bytes[b];
    if (dp) chk("mem image", big ? {v[31:0], v[63:32]} : v, got);
    else chk("mem word", v[31:0], got[63:32]);
  endtask

  task automatic t_regs;
    logic [31:0] rd;
    logic err;
    apb(1'b0, 8'h00, 32'h0, rd, err);
    chk("ctrl reset", 32'h0, rd);
    wr_ctrl(3'h7, 2'h3);
    apb(1'b0, 8'h00, 32'h0, rd, err);
    chk("ctrl readback", 32'h37, rd);
    apb(1'b0, 8'h0c, 32'h0, rd, err);
    chk("unmapped error", 1'b1, err);
    $display("test regs done");
  endtask

  task automatic t_vec;
    wr_ctrl(3'h5, 2'h0);
    run_op(fp_bank_pkg::OP_ARITH3, 0, 11, 22, 31, 6, 1, 1, 1, 1);
    wr_ctrl(3'h3, 2'h0);
    run_op(fp_bank_pkg::OP_ARITH3, 0, 16, 0, 8, 4, 1, 1, 1, 1);
    $display("test vector done");
  endtask

  task automatic t_scalar;
    wr_ctrl(3'h1, 2'h0);
    run_op(fp_bank_pkg::OP_ARITH3, 1, 12, 8, 2, 2, 1, 1, 0, 1);
    run_op(fp_bank_pkg::OP_ARITH3, 0, 0, 0, 31, 1, 0, 0, 0, 1);
    run_op(fp_bank_pkg::OP_SCALAR_ONLY, 0, 12, 20, 8, 1, 0, 0, 0, 1);
    run_op(fp_bank_pkg::OP_ARITH2, 0, 24, 26, 9, 2, 1, 1, 1, 1);
    run_op(fp_bank_pkg::OP_ARITH2, 1, 4, 8, 8, 2, 1, 1, 1, 1);
    $display("test scalar done");
  endtask

  task automatic t_stride;
    for (int s = 1; s < 4; s++) begin
      wr_ctrl(3'h2, 2'(s));
      run_op(fp_bank_pkg::OP_ARITH3, 0, 14, 21, 30, 3, 2, 2, 2, 1);
    end
    $display("test stride done");
  endtask

  task automatic t_multi;
    run_op(fp_bank_pkg::OP_MULTI, 0, 6, 0, 0, 4, 1, 0, 0, 0);
    run_op(fp_bank_pkg::OP_MULTI, 1, 7, 0, 0, 3, 1, 0, 0, 0);
    $display("test multi done");
  endtask

  task automatic t_store;
    store(0, 0, 32'h4000_0004, 64'h0000_0000_a1b2_c3d4);
    store(0, 1, 32'h4000_0004, 64'h0000_0000_5566_7788);
    store(1, 0, 32'h4000_0000, 64'h8877_6655_4433_2211);
    store(1, 1, 32'h4000_0000, 64'h0102_0304_0506_0708);
    $display("test store done");
  endtask

  task automatic t_xlat;
    for (int i = 0; i < 8; i++) begin
      @(posedge ref_clk);
      sysctl_endian_big <= i[2];
      xlat_req <= 1'b1;
      xlat_addr_in <= 32'h4000_0000 + 32'(i[1:0]);
      @(posedge ref_clk);
      xlat_req <= 1'b0;
      @(negedge ref_clk);
      chk("xlat_valid", 1'b1, xlat_valid);
      chk("xlat_addr", 32'h4000_0000 + 32'(i[1:0] ^ {2{i[2]}}), xlat_addr);
    end
    $display("test xlat done");
  endtask

  initial begin
    repeat (16) @(posedge ref_clk);
    rst_b <= 1'b1;
    t_regs();
    t_vec();
    t_scalar();
    t_stride();
    t_multi();
    t_store();
    t_xlat();
    stop_test();
  end
endmodule
